// >>> rtl/dram_rank_power_state_control.sv
// Rank power-state control: dynamic power-down, self-refresh, unused I/O.
// Assumes package sleep inputs arrive asynchronously; the rest is on clk.
`timescale 1ns/1ps
`default_nettype none

module dram_rank_power_state_control
	import dram_pm_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic [CFG_W-1:0]     power_down_config_reg,
	input  wire logic                 cfg_wr,
	input  wire logic [NUM_RANKS-1:0] rank_populated,
	input  wire logic [NUM_RANKS-1:0] gfx_rank,
	input  wire logic                 channel_used,
	input  wire logic                 req_valid,
	input  wire logic [RANK_W-1:0]    req_rank,
	input  wire logic                 req_pending,
	input  wire logic                 refresh_due,
	input  wire logic                 refresh_done,
	input  wire logic [NUM_RANKS-1:0] pre_done,
	input  wire logic                 pkg_deep_sleep_a,
	input  wire logic                 s0_idle_a,
	input  wire logic                 suspend_a,
	output rank_pins_t [NUM_RANKS-1:0] rank_pins,
	output chan_io_t                  chan_io,
	output logic [NUM_RANKS-1:0]      pre_req,
	output logic [NUM_RANKS-1:0]      cmd_ok,
	output logic [NUM_RANKS-1:0]      sref_active,
	output logic                      refresh_go,
	output logic                      memory_device_reset_n,
	output logic                      train_restore
);

	// ************************************************************
	// Sleep-state synchronisers
	// ************************************************************
	logic [2:0] sync1_q, sync2_q, sync3_q, sync_st_q;
	logic [2:0] async_in;

	assign async_in = {suspend_a, s0_idle_a, pkg_deep_sleep_a};

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sync1_q   <= '0;
			sync2_q   <= '0;
			sync3_q   <= '0;
			sync_st_q <= '0;
		end
		else
		begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (int i = 0; i < 3; i++)
				if (sync2_q[i] == sync3_q[i])
					sync_st_q[i] <= sync3_q[i];
		end
	end

	logic deep_sleep, s0_idle, suspend;
	assign deep_sleep = sync_st_q[0];
	assign s0_idle    = sync_st_q[1];
	assign suspend    = sync_st_q[2];

	// ************************************************************
	// Configuration release and memory reset
	// ************************************************************
	logic release_q;
	logic mem_rst_n_q;
	logic [3:0] pd_type;
	logic [LIMIT_W-1:0] idle_limit;
	logic dyn_en;
	logic [NUM_RANKS-1:0] eff_pop;

	assign pd_type    = power_down_config_reg[TYPE_MSB:TYPE_LSB];
	assign idle_limit = power_down_config_reg[LIMIT_MSB:LIMIT_LSB];
	assign dyn_en     = release_q && (pd_type != TYPE_NONE);

	// Until firmware speaks, every rank counts as populated
	assign eff_pop = release_q ? rank_populated : '1;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			release_q <= 1'b0;
		else if (cfg_wr)
			release_q <= 1'b1;
	end

	// Reset level is held by this register through I/O power gating
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			mem_rst_n_q <= 1'b0;
		else if (cfg_wr)
			mem_rst_n_q <= 1'b1;
	end

	assign memory_device_reset_n = mem_rst_n_q;

	// ************************************************************
	// Self-refresh request and training restore
	// ************************************************************
	logic sr_want;
	logic sleep_q;
	logic train_q;

	assign sr_want = release_q && !req_pending &&
		(suspend || (s0_idle && deep_sleep));

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sleep_q <= 1'b0;
			train_q <= 1'b0;
		end
		else
		begin
			sleep_q <= suspend || deep_sleep;
			train_q <= sleep_q && !(suspend || deep_sleep);
		end
	end

	assign train_restore = train_q;

	// ************************************************************
	// Refresh sequencing
	// ************************************************************
	logic ref_pend_q, ref_busy_q, ref_end_q;
	rank_state_t [NUM_RANKS-1:0] st_q;
	logic [NUM_RANKS-1:0] awake;
	logic [NUM_RANKS-1:0] exit_busy, idle_exp, arrive;

	always_comb
	begin
		for (int r = 0; r < NUM_RANKS; r++)
			awake[r] = !eff_pop[r] || (st_q[r] == RS_SREF) ||
				(st_q[r] == RS_ACTIVE);
	end

	assign refresh_go = ref_pend_q && !ref_busy_q && (&awake);

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			ref_pend_q <= 1'b0;
			ref_busy_q <= 1'b0;
			ref_end_q  <= 1'b0;
		end
		else
		begin
			if (refresh_due)
				ref_pend_q <= 1'b1;
			else if (refresh_go)
				ref_pend_q <= 1'b0;
			if (refresh_go)
				ref_busy_q <= 1'b1;
			else if (refresh_done)
				ref_busy_q <= 1'b0;
			ref_end_q <= ref_busy_q && refresh_done && dyn_en;
		end
	end

	// ************************************************************
	// Per-rank state machines
	// ************************************************************
	logic [NUM_RANKS-1:0] exit_start;
	logic [EXIT_W-1:0]    exit_len [NUM_RANKS];

	genvar g;
	generate
		for (g = 0; g < NUM_RANKS; g++)
		begin : g_rank
			assign arrive[g] = req_valid && (req_rank == RANK_W'(g));
			rank_timers u_timers (
				.clk          (clk),
				.rst_b        (rst_b),
				.arrive       (arrive[g]),
				.limit        (idle_limit),
				.exit_start   (exit_start[g]),
				.exit_len     (exit_len[g]),
				.idle_expired (idle_exp[g]),
				.exit_busy    (exit_busy[g])
			);
		end
	endgenerate

	always_comb
	begin
		for (int r = 0; r < NUM_RANKS; r++)
		begin
			exit_start[r] = 1'b0;
			exit_len[r]   = TXP_CYC;
			if (st_q[r] == RS_SREF &&
				(!sr_want || arrive[r]))
			begin
				exit_start[r] = 1'b1;
				exit_len[r]   = TXS_CYC;
			end
			else if (st_q[r] == RS_PDOWN &&
				(arrive[r] || ref_pend_q ||
				(sr_want && !gfx_rank[r])))
			begin
				exit_start[r] = 1'b1;
				exit_len[r]   = (pd_type == TYPE_OPEN) ? TXP_CYC : TXPDLL_CYC;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			for (int r = 0; r < NUM_RANKS; r++)
				st_q[r] <= RS_ACTIVE;
		end
		else
		begin
			for (int r = 0; r < NUM_RANKS; r++)
			begin
				case (st_q[r])
					RS_ACTIVE:
						if (!eff_pop[r] || !release_q)
							st_q[r] <= RS_ACTIVE;
						else if (sr_want && !gfx_rank[r])
							st_q[r] <= RS_PRECHG;
						else if (dyn_en && !ref_pend_q && !ref_busy_q &&
							(idle_exp[r] || (ref_end_q && !arrive[r])))
							st_q[r] <= (pd_type == TYPE_OPEN) ?
								RS_PDOWN : RS_PRECHG;
					RS_PRECHG:
						if (arrive[r])
							st_q[r] <= RS_ACTIVE;
						else if (pre_done[r] && sr_want && !gfx_rank[r])
							st_q[r] <= RS_SREF;
						else if (pre_done[r])
							st_q[r] <= dyn_en ? RS_PDOWN : RS_ACTIVE;
					RS_PDOWN:
						if (exit_start[r])
							st_q[r] <= RS_EXIT;
					RS_SREF:
						if (exit_start[r])
							st_q[r] <= RS_EXIT;
					RS_EXIT:
						if (!exit_busy[r])
							st_q[r] <= RS_ACTIVE;
					default:
						st_q[r] <= RS_ACTIVE;
				endcase
			end
		end
	end

	// ************************************************************
	// Pin and I/O controls
	// ************************************************************
	always_comb
	begin
		for (int r = 0; r < NUM_RANKS; r++)
		begin
			rank_pins[r].cke = release_q && eff_pop[r] &&
				(st_q[r] == RS_ACTIVE || st_q[r] == RS_PRECHG ||
				st_q[r] == RS_EXIT);
			rank_pins[r].cke_oe = eff_pop[r] && channel_used;
			rank_pins[r].cs_oe  = eff_pop[r] && channel_used;
			rank_pins[r].odt_oe = eff_pop[r] && channel_used;
			rank_pins[r].clk_oe = eff_pop[r] && channel_used;
			pre_req[r]     = (st_q[r] == RS_PRECHG);
			cmd_ok[r]      = (st_q[r] == RS_ACTIVE) && !exit_busy[r];
			sref_active[r] = (st_q[r] == RS_SREF);
		end
	end

	assign chan_io.data_oe_en    = channel_used;
	assign chan_io.rx_en         = channel_used;
	assign chan_io.rx_gate       = !channel_used;
	assign chan_io.dll_en        = channel_used && (|eff_pop);
	assign chan_io.io_power_gate = deep_sleep;
	assign chan_io.vref_en       = 1'b1;

endmodule : dram_rank_power_state_control

`default_nettype wire

// >>> rtl/dram_pm_pkg.sv
// Constants, field layouts and carrier types of the rank power-state logic.
// Assumes a 20 MHz controller clock and four ranks on one channel.

package dram_pm_pkg;

	localparam int NUM_RANKS = 4;
	localparam int RANK_W    = 2;
	localparam int CFG_W     = 16;
	localparam int LIMIT_W   = 12;
	localparam int EXIT_W    = 8;

	// ************************************************************
	// Configuration word layout
	// ************************************************************
	localparam int TYPE_MSB  = 15;
	localparam int TYPE_LSB  = 12;
	localparam int LIMIT_MSB = 11;
	localparam int LIMIT_LSB = 0;

	localparam logic [3:0] TYPE_NONE   = 4'h0;
	localparam logic [3:0] TYPE_OPEN   = 4'h1;
	localparam logic [3:0] TYPE_CLOSED = 4'h6;

	localparam logic [CFG_W-1:0] CFG_USUAL = 16'h6080;

	// ************************************************************
	// Exit timing
	// ************************************************************
	localparam int CLK_NS     = 50;
	localparam int TXP_NS     = 24;
	localparam int TXS_NS     = 270;
	localparam int TXPDLL_CLK = 20;

	localparam logic [EXIT_W-1:0] TXP_CYC =
		EXIT_W'((TXP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [EXIT_W-1:0] TXS_CYC =
		EXIT_W'((TXS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [EXIT_W-1:0] TXPDLL_CYC = EXIT_W'(TXPDLL_CLK);

	localparam int SYNC_STAGES = 3;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		RS_ACTIVE = 3'h0,
		RS_PRECHG = 3'h1,
		RS_PDOWN  = 3'h3,
		RS_EXIT   = 3'h2,
		RS_SREF   = 3'h6
	} rank_state_t;

	typedef struct packed {
		logic cke;
		logic cke_oe;
		logic cs_oe;
		logic odt_oe;
		logic clk_oe;
	} rank_pins_t;

	typedef struct packed {
		logic rx_en;
		logic rx_gate;
		logic dll_en;
		logic data_oe_en;
		logic io_power_gate;
		logic vref_en;
	} chan_io_t;

endpackage : dram_pm_pkg

// >>> rtl/rank_timers.sv
// Per-rank idle counter and power-up exit timer.
// Assumes arrival and start strobes on the controller clock.
`timescale 1ns/1ps
`default_nettype none

module rank_timers
	import dram_pm_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               arrive,
	input  wire logic [LIMIT_W-1:0] limit,
	input  wire logic               exit_start,
	input  wire logic [EXIT_W-1:0]  exit_len,
	output logic                    idle_expired,
	output logic                    exit_busy
);

	logic [LIMIT_W-1:0] idle_q;
	logic [EXIT_W-1:0]  exit_q;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			idle_q <= '0;
		else if (arrive)
			idle_q <= '0;
		else if (idle_q < limit)
			idle_q <= idle_q + LIMIT_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			exit_q <= '0;
		else if (exit_start)
			exit_q <= exit_len;
		else if (exit_q != '0)
			exit_q <= exit_q - EXIT_W'(1);
	end

	assign idle_expired = !arrive && (idle_q >= limit);
	assign exit_busy    = (exit_q != '0);

endmodule : rank_timers

`default_nettype wire

// >>> verif/dram_pm_checker.sv
// Port assertions for the rank power-state logic.
// Assumes rank_populated and gfx_rank stay steady while out of reset.
`timescale 1ns/1ps
`default_nettype none

module dram_pm_checker
	import dram_pm_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic [CFG_W-1:0]      power_down_config_reg,
	input  wire logic                  cfg_wr,
	input  wire logic [NUM_RANKS-1:0]  rank_populated,
	input  wire logic [NUM_RANKS-1:0]  gfx_rank,
	input  wire logic                  channel_used,
	input  wire logic                  req_pending,
	input  wire rank_pins_t [NUM_RANKS-1:0] rank_pins,
	input  wire chan_io_t              chan_io,
	input  wire logic [NUM_RANKS-1:0]  pre_req,
	input  wire logic [NUM_RANKS-1:0]  cmd_ok,
	input  wire logic [NUM_RANKS-1:0]  sref_active,
	input  wire logic                  refresh_go,
	input  wire logic                  memory_device_reset_n,
	input  wire logic                  train_restore
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic                 rel_q;
	logic [NUM_RANKS-1:0] cke_v;

	always_ff @(posedge clk)
		if (!rst_b)
			rel_q <= 1'b0;
		else if (cfg_wr)
			rel_q <= 1'b1;

	always_comb
		for (int i = 0; i < NUM_RANKS; i++)
			cke_v[i] = rank_pins[i].cke;

	sequence sref_exit_s;
		$fell(sref_active[0]);
	endsequence

	sequence closed_drop_s;
		$fell(cke_v[0]) ##0
		power_down_config_reg[TYPE_MSB:TYPE_LSB] == TYPE_CLOSED;
	endsequence

	cke_hold_a: assert property (!rel_q |-> cke_v == 4'h0)
		else $error("cke high before config write");
	reset_hold_a: assert property (!rel_q |-> !memory_device_reset_n)
		else $error("memory reset released early");
	sref_cke_a: assert property ((sref_active & cke_v) == 4'h0)
		else $error("cke high in self-refresh");
	gfx_awake_a: assert property ((sref_active & gfx_rank) == 4'h0)
		else $error("graphics rank in self-refresh");
	pend_block_a: assert property ($rose(sref_active[0])
		|-> !$past(req_pending)) else $error("self-refresh with pending");
	unpop_off_a: assert property (rel_q && !rank_populated[3]
		|=> rank_pins[3] == '0) else $error("unpopulated rank driven");
	chan_off_a: assert property (!channel_used ##1 !channel_used
		|-> chan_io.rx_gate && !chan_io.rx_en && !chan_io.data_oe_en
		&& !chan_io.dll_en) else $error("unused channel not off");
	io_keep_a: assert property (chan_io.io_power_gate[*2]
		|-> chan_io.vref_en && $stable(memory_device_reset_n))
		else $error("critical pins lost in gating");
	pre_first_a: assert property (closed_drop_s
		|-> $past(pre_req[0])) else $error("cke dropped before precharge");
	ref_wake_a: assert property (refresh_go && rel_q
		|-> (cke_v | sref_active | ~rank_populated) == 4'hf)
		else $error("refresh with rank powered down");
	exit_wait_a: assert property (sref_exit_s
		|-> !cmd_ok[0] [*5]) else $error("command before exit time");
	restore_pulse_a: assert property (train_restore
		|=> !train_restore) else $error("restore pulse too long");
endmodule : dram_pm_checker

bind dram_rank_power_state_control dram_pm_checker dram_pm_checker_inst (
	.clk                   (clk),
	.rst_b                 (rst_b),
	.power_down_config_reg (power_down_config_reg),
	.cfg_wr                (cfg_wr),
	.rank_populated        (rank_populated),
	.gfx_rank              (gfx_rank),
	.channel_used          (channel_used),
	.req_pending           (req_pending),
	.rank_pins             (rank_pins),
	.chan_io               (chan_io),
	.pre_req               (pre_req),
	.cmd_ok                (cmd_ok),
	.sref_active           (sref_active),
	.refresh_go            (refresh_go),
	.memory_device_reset_n (memory_device_reset_n),
	.train_restore         (train_restore)
);

`default_nettype wire

// >>> verif/rank_partner.sv
// Memory rank model: answers precharge and refresh requests.
// Assumes requests are levels or pulses on the controller clock.
`timescale 1ns/1ps
`default_nettype none

module rank_partner
	import dram_pm_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 slow,
	input  wire logic [NUM_RANKS-1:0] pre_req,
	input  wire logic                 refresh_go,
	output logic      [NUM_RANKS-1:0] pre_done,
	output logic                      refresh_done
);
	int wait_q [NUM_RANKS] = '{default: 0};
	int rf_q = 0;

	initial
	begin
		pre_done = '0;
		refresh_done = 1'b0;
	end

	// Precharge takes two or six cycles, refresh five
	always @(posedge clk)
	begin
		for (int i = 0; i < NUM_RANKS; i++)
		begin
			pre_done[i] <= 1'b0;
			wait_q[i] <= (pre_req[i] && !pre_done[i]) ? wait_q[i] + 1 : 0;
			if (pre_req[i] && !pre_done[i] && wait_q[i] >= (slow ? 5 : 1))
				pre_done[i] <= 1'b1;
		end
		refresh_done <= rf_q == 1;
		rf_q <= refresh_go ? 4 : (rf_q > 0 ? rf_q - 1 : 0);
	end
endmodule : rank_partner

`default_nettype wire

// >>> verif/dram_rank_power_state_control_bench.sv
// Self-checking bench for the rank power-state logic.
// Assumes the rank model answers precharge and refresh.
`timescale 1ns/1ps
`default_nettype none

module dram_rank_power_state_control_bench
	import dram_pm_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b, cfg_wr, channel_used, req_valid, req_pending, slow;
	logic refresh_due, pkg_deep_sleep_a, s0_idle_a, suspend_a;
	logic refresh_go, refresh_done, memory_device_reset_n, train_restore;
	logic [CFG_W-1:0]     power_down_config_reg;
	logic [NUM_RANKS-1:0] rank_populated, gfx_rank, pre_req, pre_done;
	logic [NUM_RANKS-1:0] cmd_ok, sref_active;
	logic [RANK_W-1:0]    req_rank;
	rank_pins_t [NUM_RANKS-1:0] rank_pins;
	chan_io_t             chan_io;
	logic [3:0]           ty [2] = '{TYPE_OPEN, TYPE_CLOSED};
	logic                 seen, ok;
	int                   n_errors = 0, checked = 0, k, lim, xs;

	always #25 clk = ~clk;

	dram_rank_power_state_control dram_rank_power_state_control_inst (
		.clk                   (clk),
		.rst_b                 (rst_b),
		.power_down_config_reg (power_down_config_reg),
		.cfg_wr                (cfg_wr),
		.rank_populated        (rank_populated),
		.gfx_rank              (gfx_rank),
		.channel_used          (channel_used),
		.req_valid             (req_valid),
		.req_rank              (req_rank),
		.req_pending           (req_pending),
		.refresh_due           (refresh_due),
		.refresh_done          (refresh_done),
		.pre_done              (pre_done),
		.pkg_deep_sleep_a      (pkg_deep_sleep_a),
		.s0_idle_a             (s0_idle_a),
		.suspend_a             (suspend_a),
		.rank_pins             (rank_pins),
		.chan_io               (chan_io),
		.pre_req               (pre_req),
		.cmd_ok                (cmd_ok),
		.sref_active           (sref_active),
		.refresh_go            (refresh_go),
		.memory_device_reset_n (memory_device_reset_n),
		.train_restore         (train_restore)
	);

	rank_partner rank_partner_inst (
		.clk          (clk),
		.slow         (slow),
		.pre_req      (pre_req),
		.refresh_go   (refresh_go),
		.pre_done     (pre_done),
		.refresh_done (refresh_done)
	);

	function automatic logic [3:0] ckes();
		for (int i = 0; i < NUM_RANKS; i++)
			ckes[i] = rank_pins[i].cke;
	endfunction : ckes

	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : chk

	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask : tick

	task automatic req();
		req_valid = 1'b1;
		tick(1);
		req_valid = 1'b0;
	endtask : req

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#400000;
		n_errors++;
		tally_and_finish();
	end

	initial
	begin
		{rst_b, cfg_wr, req_valid, req_pending, slow, refresh_due} = '0;
		{pkg_deep_sleep_a, s0_idle_a, suspend_a, req_rank} = '0;
		channel_used = 1'b1;
		rank_populated = 4'h7;
		gfx_rank = 4'h4;
		power_down_config_reg = {TYPE_NONE, 12'h004};
		xs = rank_populated & ~gfx_rank;
		k = $urandom(3);
		tick(2);
		rst_b = 1'b1;
		tick(20);
		chk("cke_held", 8'h0, ckes());
		chk("reset_held", 8'h0, memory_device_reset_n);
		cfg_wr = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
		tick(2);
		chk("cke_up", 8'h7, ckes());
		chk("unpop_cs", 8'h0, rank_pins[3].cs_oe);
		$display("test reset done");
		for (int j = 0; j < 2; j++)
		begin
			lim = 4 + $urandom % 8;
			power_down_config_reg = {ty[j], 12'(lim)};
			slow = j[0];
			req();
			tick(12);
			// Keep requests coming past the longest power-down exit
			repeat (10)
			begin
				req();
				tick(lim - 2);
			end
			chk("restart", 8'h1, rank_pins[0].cke);
			req();
			seen = 1'b0;
			for (k = 0; k < lim + 12 && rank_pins[0].cke; k++)
			begin
				seen |= pre_req[0];
				tick(1);
			end
			chk("pd_time", 8'h1, k >= lim - 1 && k < lim + 12);
			chk("precharge", 8'(j), seen);
			req();
			ok = 1'b0;
			for (k = 0; k < 30; k++)
			begin
				ok |= cmd_ok[0];
				tick(1);
			end
			chk("wake", 8'h1, ok);
			$display("test power-down type %0d done", j);
		end
		power_down_config_reg = CFG_USUAL;
		lim = int'(CFG_USUAL[LIMIT_MSB:LIMIT_LSB]);
		req();
		for (k = 0; k < lim + 12 && rank_pins[0].cke; k++)
			tick(1);
		chk("usual_limit", 8'h1, k >= lim && k < lim + 12);
		$display("test usual config done");
		tick(lim + 20);
		chk("all_down", 8'h0, ckes());
		refresh_due = 1'b1;
		tick(1);
		refresh_due = 1'b0;
		for (k = 0; k < 60 && !refresh_go; k++)
			tick(1);
		chk("ref_go", 8'h1, refresh_go);
		chk("ref_wake", 8'h7, ckes());
		for (k = 0; k < 40 && ckes() != 4'h0; k++)
			tick(1);
		chk("ref_down", 8'h0, ckes());
		$display("test refresh done");
		for (int m = 0; m < 2; m++)
		begin
			req_pending = 1'b1;
			{s0_idle_a, pkg_deep_sleep_a, suspend_a} = m ? 3'h1 : 3'h6;
			tick(20);
			chk("sref_blocked", 8'h0, sref_active);
			req_pending = 1'b0;
			for (k = 0; k < 60 && sref_active != xs; k++)
				tick(1);
			chk("sref_set", 8'(xs), sref_active);
			chk("sref_cke", 8'h0, ckes() & xs);
			chk("io_gate", 8'(!m), chan_io.io_power_gate);
			chk("vref", 8'h1, chan_io.vref_en);
			chk("mem_reset", 8'h1, memory_device_reset_n);
			{s0_idle_a, pkg_deep_sleep_a, suspend_a} = 3'h0;
			{seen, ok} = 2'h0;
			for (k = 0; k < 60; k++)
			begin
				seen |= train_restore;
				ok |= cmd_ok[0];
				tick(1);
			end
			chk("restore", 8'h1, seen);
			chk("sref_exit", 8'h1, ok);
			$display("test self-refresh %0d done", m);
		end
		channel_used = 1'b0;
		tick(3);
		chk("rx_gate", 8'h1, chan_io.rx_gate);
		chk("io_off", 8'h0, {chan_io.rx_en, chan_io.data_oe_en});
		chk("dll_off", 8'h0, chan_io.dll_en);
		chk("pins_off", 8'h0, rank_pins[0].cs_oe);
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		tick(2);
		chk("cke_rst", 8'h0, ckes());
		$display("test unused channel done");
		tally_and_finish();
	end
endmodule : dram_rank_power_state_control_bench

`default_nettype wire
